// ### verilog/i2c_master_sequencer.sv
// master sequencer for the two-wire serial bus
`timescale 1ns/1ps
module i2c_master_sequencer
  import i2c_seq_pkg::*;
#(
  parameter int RATE_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  state_t state_reg;
  logic [2:0] phase_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] buf_reg;
  logic [RATE_W-1:0] rate_reg;
  logic [5:0] ctl_reg;
  logic [7:0] stat_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic gen_load;
  logic gen_run;
  logic tick;
  logic [7:0] rdata_next;
  logic buf_wr;
  logic idle;
  logic write_collision_set;

  assign idle = (state_reg == S_IDLE) || (state_reg == S_HOLD);
  assign buf_wr = i_wr && (i_addr == ADDR_BUF);
  assign write_collision_set = buf_wr && !(state_reg == S_HOLD || state_reg == S_IDLE);

  // generator is held while a released clock is still low
  bit_rate_counter #(.W(RATE_W)) u_gen (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_load(gen_load),
    .i_run(gen_run),
    .i_rate(rate_reg),
    .o_tick(tick)
  );

  assign gen_run = !idle && !(state_reg == S_WAITH) && !(state_reg == S_DONE);

  // sequencer: phase_reg walks the steps of the start, restart and stop sequences
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
      phase_reg <= 3'h0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      gen_load <= 1'b0;
    end else begin
      gen_load <= 1'b0;
      case (state_reg)
        S_IDLE, S_HOLD: begin
          phase_reg <= 3'h0;
          if (ctl_reg[CTL_SEN]) begin
            if (i_scl && i_sda) begin
              state_reg <= S_START;
              gen_load <= 1'b1;
            end else begin
              // a line already low at the start is a collision; stay idle
              state_reg <= S_IDLE;
              scl_low_reg <= 1'b0;
              sda_low_reg <= 1'b0;
            end
          end else if (ctl_reg[CTL_REPEATED_START_ENABLE]) begin
            state_reg <= S_RSTART;
            scl_low_reg <= 1'b1;
          end else if (ctl_reg[CTL_PEN]) begin
            state_reg <= S_STOP;
            sda_low_reg <= 1'b1;
            gen_load <= 1'b1;
          end else if (ctl_reg[CTL_RECEIVE_ENABLE]) begin
            state_reg <= S_RX;
            bit_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            gen_load <= 1'b1;
          end else if (ctl_reg[CTL_ACK_SEQUENCE_ENABLE]) begin
            state_reg <= S_ACK;
            scl_low_reg <= 1'b1;
            sda_low_reg <= !ctl_reg[CTL_ACK_DATA_VALUE];
            gen_load <= 1'b1;
          end else if (buf_wr && state_reg == S_HOLD) begin
            state_reg <= S_TX;
            shift_reg <= i_wdata;
            bit_reg <= 4'h0;
            sda_low_reg <= !i_wdata[7];
            gen_load <= 1'b1;
          end
        end
        S_START: begin
          if (phase_reg == 3'h0 && !i_scl) begin
            state_reg <= S_IDLE;
          end else if (tick && phase_reg == 3'h0) begin
            sda_low_reg <= 1'b1;
            phase_reg <= 3'h1;
          end else if (tick) begin
            scl_low_reg <= 1'b1;
            state_reg <= S_HOLD;
          end
        end
        S_RSTART: begin
          if (phase_reg == 3'h0 && !i_scl) begin
            sda_low_reg <= 1'b0;
            gen_load <= 1'b1;
            phase_reg <= 3'h1;
          end else if (phase_reg == 3'h1 && tick) begin
            if (i_sda) begin
              scl_low_reg <= 1'b0;
              state_reg <= S_WAITH;
              phase_reg <= 3'h2;
            end
          end else if (phase_reg == 3'h2 && tick) begin
            sda_low_reg <= 1'b1;
            phase_reg <= 3'h3;
          end else if (phase_reg == 3'h3 && tick) begin
            scl_low_reg <= 1'b1;
            state_reg <= S_HOLD;
          end
          if (phase_reg >= 3'h2 && !i_scl) begin
            state_reg <= S_IDLE;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
          end
        end
        S_TX, S_RX, S_ACK: begin
          if (tick && scl_low_reg) begin
            scl_low_reg <= 1'b0;
            state_reg <= S_WAITH;
            phase_reg <= {1'b0, state_reg == S_RX, state_reg == S_RX || state_reg == S_ACK};
          end else if (tick) begin
            scl_low_reg <= 1'b1;
            if (state_reg == S_ACK) begin
              state_reg <= S_HOLD;
            end else if (bit_reg == BIT_COUNT + 4'h1) begin
              state_reg <= S_HOLD;
              sda_low_reg <= 1'b0;
            end else if (state_reg == S_RX && bit_reg == BIT_COUNT) begin
              state_reg <= S_HOLD;
            end else if (state_reg == S_TX && bit_reg == BIT_COUNT) begin
              sda_low_reg <= 1'b0;
            end else if (state_reg == S_TX) begin
              sda_low_reg <= !shift_reg[7];
            end
          end
        end
        S_WAITH: begin
          // clock stretching by a slave holds us here
          if (i_scl) begin
            gen_load <= 1'b1;
            if (phase_reg == 3'h2) begin
              if (i_sda) begin
                state_reg <= S_RSTART;
              end else begin
                state_reg <= S_IDLE;
                sda_low_reg <= 1'b0;
              end
            end else if (phase_reg == 3'h0) begin
              state_reg <= S_TX;
              if (bit_reg < BIT_COUNT) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
              bit_reg <= (bit_reg == BIT_COUNT) ? bit_reg + 4'h1 : bit_reg + 4'h1;
            end else if (phase_reg == 3'h1) begin
              state_reg <= S_ACK;
            end else begin
              state_reg <= S_RX;
              shift_reg <= {shift_reg[6:0], i_sda};
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        S_STOP: begin
          if (tick && phase_reg == 3'h0) begin
            scl_low_reg <= 1'b0;
            phase_reg <= 3'h1;
          end else if (tick && phase_reg == 3'h1) begin
            sda_low_reg <= 1'b0;
            phase_reg <= 3'h2;
          end else if (tick) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // phase codes for the wait state: 0 tx, 1 ack, 2 restart, 3 rx
  logic tx_done;
  logic rx_done;
  logic ack_done;
  logic start_done;
  logic rs_done;
  logic stop_done;
  logic stop_seen;
  logic ack_sample;
  logic bcl_event;
  assign tx_done = state_reg == S_TX && tick && !scl_low_reg && bit_reg == BIT_COUNT + 4'h1;
  assign ack_sample = state_reg == S_WAITH && i_scl && phase_reg == 3'h0
    && bit_reg == BIT_COUNT;
  assign rx_done = state_reg == S_RX && tick && !scl_low_reg && bit_reg == BIT_COUNT;
  assign ack_done = state_reg == S_ACK && tick && !scl_low_reg;
  assign start_done = state_reg == S_START && tick && phase_reg == 3'h1;
  assign rs_done = state_reg == S_RSTART && tick && phase_reg == 3'h3;
  assign stop_done = state_reg == S_STOP && tick && phase_reg == 3'h2;
  assign stop_seen = state_reg == S_STOP && tick && phase_reg == 3'h1;
  assign bcl_event = (state_reg == S_START && phase_reg == 3'h0 && !i_scl)
    || (state_reg == S_RSTART && phase_reg >= 3'h2 && !i_scl)
    || (state_reg == S_WAITH && phase_reg == 3'h2 && i_scl && !i_sda)
    || (idle && ctl_reg[CTL_SEN] && !(i_scl && i_sda));

  // control bits: self-clearing enables; enable writes gated while busy, CTL_ACK_DATA_VALUE always written
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctl_reg <= 6'h00;
    end else begin
      if (i_wr && i_addr == ADDR_CTRL) begin
        ctl_reg[CTL_ACK_DATA_VALUE] <= i_wdata[CTL_ACK_DATA_VALUE];
        if (idle && ctl_reg[CTL_SEN] == 1'b0) begin
          ctl_reg[CTL_SEN] <= i_wdata[CTL_SEN];
          ctl_reg[CTL_REPEATED_START_ENABLE] <= i_wdata[CTL_REPEATED_START_ENABLE];
          ctl_reg[CTL_PEN] <= i_wdata[CTL_PEN];
          ctl_reg[CTL_RECEIVE_ENABLE] <= i_wdata[CTL_RECEIVE_ENABLE];
          ctl_reg[CTL_ACK_SEQUENCE_ENABLE] <= i_wdata[CTL_ACK_SEQUENCE_ENABLE];
        end
      end
      if (start_done || bcl_event) begin
        ctl_reg[CTL_SEN] <= 1'b0;
      end
      if (rs_done || bcl_event) begin
        ctl_reg[CTL_REPEATED_START_ENABLE] <= 1'b0;
      end
      if (stop_done) begin
        ctl_reg[CTL_PEN] <= 1'b0;
      end
      if (rx_done) begin
        ctl_reg[CTL_RECEIVE_ENABLE] <= 1'b0;
      end
      if (ack_done) begin
        ctl_reg[CTL_ACK_SEQUENCE_ENABLE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rate_reg <= RATE_W'(RATE_RESET);
    end else if (i_wr && i_addr == ADDR_RATE) begin
      rate_reg <= i_wdata[RATE_W-1:0];
    end
  end

  // status flags: hardware set wins over a software clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stat_reg <= 8'h00;
      buf_reg <= 8'h00;
    end else begin
      if (i_wr && i_addr == ADDR_STAT) begin
        stat_reg <= stat_reg & ~i_wdata;
      end
      if (buf_wr && state_reg == S_HOLD && !(|ctl_reg[CTL_ACK_SEQUENCE_ENABLE:CTL_SEN])) begin
        buf_reg <= i_wdata;
        stat_reg[ST_BF] <= 1'b1;
      end
      if (write_collision_set) begin
        stat_reg[ST_WRITE_COLLISION] <= 1'b1;
      end
      if (state_reg == S_TX && tick && !scl_low_reg && bit_reg == BIT_COUNT) begin
        stat_reg[ST_BF] <= 1'b0;
      end
      if (i_rd && i_addr == ADDR_BUF) begin
        stat_reg[ST_BF] <= 1'b0;
      end
      if (ack_sample) begin
        stat_reg[ST_ACK_STATUS] <= i_sda;
      end
      if (rx_done) begin
        buf_reg <= shift_reg;
        stat_reg[ST_BF] <= 1'b1;
        if (stat_reg[ST_BF]) begin
          stat_reg[ST_OV] <= 1'b1;
        end
      end
      if (start_done || (state_reg == S_RSTART && tick && phase_reg == 3'h2)) begin
        stat_reg[ST_START] <= 1'b1;
      end
      if (stop_seen) begin
        stat_reg[ST_STOP] <= 1'b1;
      end
      if (start_done || rs_done || tx_done || rx_done || ack_done || stop_done) begin
        stat_reg[ST_IF] <= 1'b1;
      end
      if (bcl_event) begin
        stat_reg[ST_BCL] <= 1'b1;
      end
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    case (i_addr)
      ADDR_CTRL: rdata_next = {2'h0, ctl_reg};
      ADDR_STAT: rdata_next = stat_reg;
      ADDR_BUF: rdata_next = buf_reg;
      ADDR_RATE: rdata_next = 8'(rate_reg);
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rdata_next : 8'h00;
      o_scl_oe <= scl_low_reg;
      o_sda_oe <= sda_low_reg;
    end
  end

  chk_start_flag: assert property (@(posedge i_clk) disable iff (i_reset)
    start_done |=> stat_reg[ST_START] && stat_reg[ST_IF]) else $error("start flags missing");
  chk_bcl_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    bcl_event |=> stat_reg[ST_BCL]) else $error("collision not flagged");
  chk_write_collision_set: assert property (@(posedge i_clk) disable iff (i_reset)
    write_collision_set |=> stat_reg[ST_WRITE_COLLISION]) else $error("write collision lost");
  chk_rx_full: assert property (@(posedge i_clk) disable iff (i_reset)
    rx_done |=> stat_reg[ST_BF] && stat_reg[ST_IF]) else $error("rx flags missing");
  chk_ovf_set: assert property (@(posedge i_clk) disable iff (i_reset)
    rx_done && stat_reg[ST_BF] |=> stat_reg[ST_OV]) else $error("overflow lost");
  chk_ack_store: assert property (@(posedge i_clk) disable iff (i_reset)
    ack_sample |=> stat_reg[ST_ACK_STATUS] == $past(i_sda)) else $error("ack status wrong");
  chk_hold_scl: assert property (@(posedge i_clk) disable iff (i_reset)
    tx_done |=> ##1 o_scl_oe && !o_sda_oe) else $error("hold state wrong");
  chk_stop_seen: assert property (@(posedge i_clk) disable iff (i_reset)
    stop_done |=> stat_reg[ST_STOP] && state_reg == S_IDLE) else $error("stop wrong");
  cov_start: cover property (@(posedge i_clk) start_done);
  cov_tx: cover property (@(posedge i_clk) tx_done);
  cov_rx: cover property (@(posedge i_clk) rx_done);
  cov_stop: cover property (@(posedge i_clk) stop_done);
endmodule

// ### verilog/i2c_seq_pkg.sv
// constants shared by the two-wire master sequencer
package i2c_seq_pkg;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h1;
  localparam logic [2:0] ADDR_BUF = 3'h2;
  localparam logic [2:0] ADDR_RATE = 3'h3;
  // control_register_two bits
  localparam int CTL_SEN = 0;
  localparam int CTL_REPEATED_START_ENABLE = 1;
  localparam int CTL_PEN = 2;
  localparam int CTL_RECEIVE_ENABLE = 3;
  localparam int CTL_ACK_SEQUENCE_ENABLE = 4;
  localparam int CTL_ACK_DATA_VALUE = 5;
  // status_register bits, written 1 clears flags
  localparam int ST_BF = 0;
  localparam int ST_START = 1;
  localparam int ST_STOP = 2;
  localparam int ST_ACK_STATUS = 3;
  localparam int ST_WRITE_COLLISION = 4;
  localparam int ST_OV = 5;
  localparam int ST_IF = 6;
  localparam int ST_BCL = 7;
  localparam logic [7:0] RATE_RESET = 8'h09;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_START = 10'h002,
    S_RSTART = 10'h004,
    S_TX = 10'h008,
    S_RX = 10'h010,
    S_ACK = 10'h020,
    S_STOP = 10'h040,
    S_HOLD = 10'h080,
    S_WAITH = 10'h100,
    S_DONE = 10'h200
  } state_t;
endpackage

// ### verilog/bit_rate_counter.sv
// reloadable down-counter giving one tick per generator period
`timescale 1ns/1ps
module bit_rate_counter #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic i_run,
  input wire logic [W-1:0] i_rate,
  output logic o_tick
);
  logic [W-1:0] count_reg;
  // one count to zero is one period; reload restarts the period
  always_ff @(posedge i_clk) begin
    if (i_reset || i_load) begin
      count_reg <= i_rate;
    end else if (i_run) begin
      count_reg <= (count_reg == '0) ? i_rate : count_reg - W'(1);
    end
  end
  assign o_tick = i_run && !i_load && (count_reg == '0);
endmodule

// ### tb/i2c_slave_model.sv
// behavioural bus slave: acks, sends bytes, stretches the clock
`timescale 1ns/1ps
module i2c_slave_model (
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_ack_en,
  input wire logic i_read_mode,
  input wire logic [7:0] i_tx_byte,
  input wire logic [7:0] i_stretch,
  output logic o_scl_oe,
  output logic o_sda_oe,
  output logic [7:0] o_rx_byte,
  output logic [7:0] o_starts
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] hold = 8'h00;
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    o_rx_byte = 8'h00;
    o_starts = 8'h00;
  end
  always @(posedge i_clk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    // stretch ends by itself, so a stuck master cannot hang the bus here
    if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end else begin
      o_scl_oe <= 1'b0;
    end
    if (i_scl && scl_q && sda_q && !i_sda) begin
      cnt <= 4'h0;
      o_sda_oe <= 1'b0;
      o_starts <= o_starts + 8'h01;
    end else if (i_scl && !scl_q) begin
      if (cnt < 4'h8) sh <= {sh[6:0], i_sda};
      if (cnt == 4'h7) o_rx_byte <= {sh[6:0], i_sda};
      cnt <= cnt + 4'h1;
    end else if (!i_scl && scl_q) begin
      if (i_stretch != 8'h00) begin
        o_scl_oe <= 1'b1;
        hold <= i_stretch;
      end
      if (cnt < 4'h8) begin
        o_sda_oe <= i_read_mode & ~i_tx_byte[3'h7 - cnt[2:0]];
      end else if (cnt == 4'h8) begin
        o_sda_oe <= ~i_read_mode & i_ack_en;
      end else begin
        cnt <= 4'h0;
        o_sda_oe <= i_read_mode & ~i_tx_byte[7];
      end
    end else if (!i_scl && cnt == 4'h0 && i_read_mode) begin
      o_sda_oe <= ~i_tx_byte[7];
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
module testbench;
  import i2c_seq_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_scl_oe, o_sda_oe, s_scl_oe, s_sda_oe;
  logic tb_sda_low = 1'b0;
  logic ack_en = 1'b1;
  logic read_mode = 1'b0;
  logic [7:0] tx_byte = 8'h00, stretch = 8'h00, rx_byte, starts, d;
  int failures = 0, checks_done = 0, cycles = 0, n;
  // both lines have pull-ups: released means high
  wire scl = ~(o_scl_oe | s_scl_oe);
  wire sda = ~(o_sda_oe | s_sda_oe | tb_sda_low);
  always #10 i_clk = ~i_clk;
  i2c_master_sequencer i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl),
    .i_sda(sda), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));
  i2c_slave_model i_slave (.i_clk(i_clk), .i_scl(scl), .i_sda(sda), .i_ack_en(ack_en),
    .i_read_mode(read_mode), .i_tx_byte(tx_byte), .i_stretch(stretch),
    .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe), .o_rx_byte(rx_byte), .o_starts(starts));
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // polling is bounded so a lost flag reports instead of hanging
  task automatic wait_st(input int b);
    n = 0;
    do begin
      rd(ADDR_STAT);
      n++;
    end while (d[b] !== 1'b1 && n < 3000);
    chk("status flag", 8'h01, {7'h0, d[b]});
  endtask
  task automatic t_start;
    wr(ADDR_RATE, 8'h03);
    wr(ADDR_CTRL, 8'h01);
    n = 0;
    while (o_sda_oe !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    chk("start delay", 8'h01, {7'h0, n >= 3 && n <= 8});
    chk("scl at start", 8'h00, o_scl_oe);
    wait_st(ST_IF);
    rd(ADDR_STAT);
    chk("start seen", 8'h01, d[ST_START]);
    rd(ADDR_CTRL);
    chk("start enable", 8'h00, d[CTL_SEN]);
    chk("sda held", 8'h01, o_sda_oe);
    wr(ADDR_STAT, 8'hfe);
  endtask
  task automatic t_tx(input logic [7:0] b, input logic ack);
    ack_en <= ack;
    wr(ADDR_BUF, b);
    rd(ADDR_STAT);
    chk("full", 8'h01, d[ST_BF]);
    wr(ADDR_BUF, 8'h00);
    wr(ADDR_CTRL, 8'h0a);
    wait_st(ST_IF);
    rd(ADDR_STAT);
    chk("write_collision", 8'h01, d[ST_WRITE_COLLISION]);
    chk("full", 8'h00, d[ST_BF]);
    chk("ack status", !ack, d[ST_ACK_STATUS]);
    rd(ADDR_CTRL);
    chk("busy ctrl", 8'h00, d & 8'h0a);
    chk("byte", b, rx_byte);
    chk("scl low", 8'h01, o_scl_oe);
    chk("sda free", 8'h00, o_sda_oe);
    wr(ADDR_STAT, 8'hfe);
  endtask
  task automatic t_restart;
    wr(ADDR_CTRL, 8'h02);
    wait_st(ST_IF);
    rd(ADDR_CTRL);
    chk("restart enable", 8'h00, d[CTL_REPEATED_START_ENABLE]);
    rd(ADDR_STAT);
    chk("start seen", 8'h01, d[ST_START]);
    chk("slave starts", 8'h02, starts);
    chk("lines held", 8'h03, {6'h0, o_scl_oe, o_sda_oe});
    wr(ADDR_STAT, 8'hfe);
  endtask
  task automatic t_rx(input logic [7:0] b, input logic ov, input logic take);
    tx_byte <= b;
    read_mode <= 1'b1;
    wr(ADDR_CTRL, 8'h08);
    wait_st(ST_IF);
    rd(ADDR_CTRL);
    chk("receive enable", 8'h00, d[CTL_RECEIVE_ENABLE]);
    rd(ADDR_STAT);
    chk("full", 8'h01, d[ST_BF]);
    chk("overflow", ov, d[ST_OV]);
    chk("scl low", 8'h01, o_scl_oe);
    if (take) begin
      rd(ADDR_BUF);
      chk("rx byte", b, d);
      rd(ADDR_STAT);
      chk("full", 8'h00, d[ST_BF]);
    end
    wr(ADDR_STAT, 8'hfe);
  endtask
  task automatic t_ack(input logic v);
    read_mode <= !v;
    wr(ADDR_CTRL, v ? 8'h30 : 8'h10);
    n = 0;
    while (scl !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    chk("ack drive", !v, o_sda_oe);
    n = 0;
    do begin
      rd(ADDR_CTRL);
      n++;
    end while (d[CTL_ACK_SEQUENCE_ENABLE] !== 1'b0 && n < 500);
    chk("ack enable", 8'h00, d[CTL_ACK_SEQUENCE_ENABLE]);
    chk("scl low", 8'h01, o_scl_oe);
    // the ack sets the interrupt; clear it so the next wait sees a fresh one
    wr(ADDR_STAT, 8'hfe);
  endtask
  task automatic t_stop;
    wr(ADDR_CTRL, 8'h04);
    wait_st(ST_IF);
    rd(ADDR_STAT);
    chk("stop seen", 8'h01, d[ST_STOP]);
    rd(ADDR_CTRL);
    chk("stop enable", 8'h00, d[CTL_PEN]);
    chk("lines free", 8'h00, {6'h0, o_scl_oe, o_sda_oe});
    wr(ADDR_STAT, 8'hfe);
  endtask
  task automatic t_coll;
    tb_sda_low <= 1'b1;
    wr(ADDR_CTRL, 8'h01);
    wait_st(ST_BCL);
    rd(ADDR_CTRL);
    chk("start enable", 8'h00, d[CTL_SEN]);
    chk("lines free", 8'h00, {6'h0, o_scl_oe, o_sda_oe});
    tb_sda_low <= 1'b0;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    chk("oe after reset", 8'h00, {6'h0, o_scl_oe, o_sda_oe});
    rd(ADDR_RATE);
    chk("rate reset", RATE_RESET, d);
    t_start();
    t_tx(8'ha6, 1'b1);
    stretch <= 8'h06;
    t_tx(8'h3c, 1'b0);
    stretch <= 8'h00;
    t_restart();
    t_tx(8'ha7, 1'b1);
    t_rx(8'h5a, 1'b0, 1'b1);
    t_ack(1'b0);
    t_rx(8'hc3, 1'b0, 1'b0);
    t_ack(1'b0);
    t_rx(8'h96, 1'b1, 1'b0);
    t_ack(1'b1);
    t_stop();
    t_coll();
    end_sim();
  end
endmodule
